//--- logic/psd_data_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "psd_defs.svh"
// Contract
// [R01] Clock counts only while hold input low
// [R02] Hold stretches cycle, never deselects
// [R03] Controller may hold indefinitely without reissue
// [R04] Input data and parity captured on rise
// [R05] Read data appears one cycle after address; code drives it two cycles after
// [R06] Output enable high tristates, low allows drive
// [R07] Tristate on write data, deselect, wake
// [R08] Parity lanes follow data, per-lane byte select
// [R09] Strap high interleaved, low linear burst
// [R10] Strap kept fixed during operation
// [R11] Byte selects active low, qualified by write
// [R12] Hold freezes output drive state too; code still turns drive off if output enable goes high during hold
module psd_data_port #(
  parameter int LANES = `PSD_LANES,
  parameter int ADDR_W = `PSD_ADDR_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic clk_qualify_n,
  input wire logic chipSel_n,
  input wire logic writeEn_n,
  input wire logic advLoad_n,
  input wire logic outEn_n,
  input wire logic burstModePin,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic [LANES-1:0] byte_write_sel_n,
  input wire logic [LANES*8-1:0] dataIn,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES*8-1:0] dataOut,
  output logic [LANES-1:0] parity_lines_out,
  output logic [LANES-1:0] parity_lines_oe_n,
  output logic [LANES*8-1:0] dataOe_n
);
  // ==========================================
  // Pin synchronisers
  // ==========================================
  logic [1:0] holdSync;
  logic [1:0] oeSync;
  logic [1:0] modeSync;
  logic run;
  logic oeLow;
  logic modeHigh;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdSync <= 2'h3;
      oeSync <= 2'h3;
      modeSync <= 2'h3;
    end else if (clkEn) begin
      holdSync <= {holdSync[0], clk_qualify_n};
      oeSync <= {oeSync[0], outEn_n};
      modeSync <= {modeSync[0], burstModePin};
    end
  end

  assign run = clkEn && !holdSync[1]; // R01
  assign oeLow = !oeSync[1];
  assign modeHigh = modeSync[1];

  // ==========================================
  // Control pipeline
  // ==========================================
  psd_mem_if mif();

  psd_pkg::psd_op_t op;
  psd_pkg::psd_op_t next_op;
  psd_pkg::psd_op_t dataOp;
  psd_pkg::psd_op_t next_dataOp;
  psd_pkg::psd_order_t order;
  psd_pkg::psd_order_t next_order;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [1:0] burstCnt;
  logic [1:0] next_burstCnt;
  logic [LANES-1:0] lanes;
  logic [LANES-1:0] next_lanes;
  logic [1:0] baseLow;
  logic [1:0] next_baseLow;
  logic wake;
  logic next_wake;
  logic [1:0] offs;

  always_comb begin
    next_op = op;
    next_order = order;
    next_addr = addr;
    next_burstCnt = burstCnt;
    next_lanes = lanes;
    next_dataOp = dataOp;
    next_baseLow = baseLow;
    next_wake = wake;
    offs = 2'h0;
    if (run) begin // R02 R03
      // R09: strap order sampled every running cycle, kept steady by the system
      next_order = modeHigh ? psd_pkg::PSD_INTERLEAVED : psd_pkg::PSD_LINEAR;
      if (!advLoad_n) begin
        next_burstCnt = `PSD_BURST_ZERO;
        next_addr = addrIn;
        next_baseLow = addrIn[1:0];
        if (chipSel_n) begin
          next_op = psd_pkg::PSD_IDLE;
        end else if (!writeEn_n) begin
          next_op = psd_pkg::PSD_WRITE;
        end else begin
          next_op = psd_pkg::PSD_READ;
        end
      end else if (op != psd_pkg::PSD_IDLE) begin
        next_burstCnt = 2'(burstCnt + `PSD_BURST_ONE);
        // Burst offsets count from the loaded address, not the last one
        offs = (order == psd_pkg::PSD_INTERLEAVED) ?
               (baseLow ^ next_burstCnt) : 2'(baseLow + next_burstCnt);
        next_addr = {addr[ADDR_W-1:2], offs};
      end
      // R11: selects sampled with write strobe
      next_lanes = (!writeEn_n) ? ~byte_write_sel_n : '0; // R11
      next_dataOp = op;
      next_wake = (dataOp == psd_pkg::PSD_IDLE) && (op != psd_pkg::PSD_IDLE);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op <= psd_pkg::PSD_IDLE;
      dataOp <= psd_pkg::PSD_IDLE;
      order <= psd_pkg::PSD_INTERLEAVED;
      addr <= '0;
      burstCnt <= `PSD_BURST_ZERO;
      lanes <= '0;
      baseLow <= 2'h0;
      wake <= 1'b0;
    end else begin
      op <= next_op;
      dataOp <= next_dataOp;
      order <= next_order;
      addr <= next_addr;
      burstCnt <= next_burstCnt;
      lanes <= next_lanes;
      baseLow <= next_baseLow;
      wake <= next_wake;
    end
  end

  // ==========================================
  // Write data capture
  // ==========================================
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gPack
      assign mif.wrData[g*9 +: 9] = {parity_lines_in[g], dataIn[g*8 +: 8]}; // R04 R08
      // Pins are stored at the edge closing the data phase, so a read
      // right behind the write already sees the new word
      assign mif.wrLane[g] = (op == psd_pkg::PSD_WRITE) && lanes[g]; // R08
    end
  endgenerate
  assign mif.addr = addr;
  assign mif.hold = !run;

  psd_array #(
    .DEPTH(1 << ADDR_W)
  ) uArray (
    .clk(clk),
    .port(mif.mem)
  );

  // ==========================================
  // Output drive
  // ==========================================
  // Data pins are registered again here behind the array's read register, along with the enables
  logic drive;
  logic next_drive;
  logic [LANES*8-1:0] next_dataOut;
  logic [LANES-1:0] next_parOut;
  logic inWrite;

  // A write data phase follows at once; release the lines before it
  assign inWrite = !advLoad_n ? (!chipSel_n && !writeEn_n) :
                   (op == psd_pkg::PSD_WRITE);

  always_comb begin
    next_drive = drive; // R12
    next_dataOut = dataOut;
    next_parOut = parity_lines_out;
    if (run) begin
      // Read data leaves two cycles after its address was taken
      next_drive = (dataOp == psd_pkg::PSD_READ) && !inWrite && oeLow; // R05 R06 R07
      for (int i = 0; i < LANES; i++) begin
        next_dataOut[i*8 +: 8] = mif.rdData[i*9 +: 8]; // R05
        next_parOut[i] = mif.rdData[i*9 + 8]; // R08
      end
    end else if (!oeLow) begin
      next_drive = 1'b0; // R06
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive <= 1'b0;
      dataOut <= '0;
      parity_lines_out <= '0;
      dataOe_n <= '1;
      parity_lines_oe_n <= '1;
    end else if (clkEn) begin
      drive <= next_drive;
      dataOut <= next_dataOut;
      parity_lines_out <= next_parOut;
      dataOe_n <= {(LANES*8){!next_drive}}; // R07
      parity_lines_oe_n <= {LANES{!next_drive}}; // R08
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  chk_write_tristate: assert property (@(posedge clk) disable iff (reset) // R07
    (run && (inWrite || dataOp == psd_pkg::PSD_WRITE)) |=> dataOe_n == '1)
    else $error("Drive during write data phase");
  chk_idle_tristate: assert property (@(posedge clk) disable iff (reset) // R07
    (run && dataOp == psd_pkg::PSD_IDLE) |=> parity_lines_oe_n == '1)
    else $error("Drive while deselected");
  chk_wake_tristate: assert property (@(posedge clk) disable iff (reset) // R07
    wake |-> dataOe_n == '1)
    else $error("Drive in first cycle after deselect");
  chk_hold_freeze: assert property (@(posedge clk) disable iff (reset) // R01
    (clkEn && holdSync[1]) |=> $stable(op) && $stable(addr))
    else $error("State moved under hold");
  chk_oe_off: assert property (@(posedge clk) disable iff (reset) // R06
    (clkEn && oeSync[1]) |=> dataOe_n == '1)
    else $error("Drive with output enable high");
  chk_read_drive: assert property (@(posedge clk) disable iff (reset) // R05
    (run && dataOp == psd_pkg::PSD_READ && !inWrite && oeLow) |=>
    dataOe_n == '0)
    else $error("Read data not driven");
  chk_hold_keep: assert property (@(posedge clk) disable iff (reset) // R12
    (clkEn && holdSync[1] && oeLow) |=> $stable(drive))
    else $error("Drive changed under hold");
  chk_lane_gate: assert property (@(posedge clk) disable iff (reset) // R08
    (op != psd_pkg::PSD_WRITE) |-> mif.wrLane == '0)
    else $error("Lane write outside write phase");
  chk_sel_qual: assert property (@(posedge clk) disable iff (reset) // R11
    (run && writeEn_n) |=> lanes == '0)
    else $error("Lanes set without write strobe");
  chk_order_sel: assert property (@(posedge clk) disable iff (reset) // R09
    (run && modeHigh) |=> order == psd_pkg::PSD_INTERLEAVED)
    else $error("Wrong burst order");
endmodule
`default_nettype wire

//--- logic/psd_defs.svh
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH
`define PSD_LANES 4
`define PSD_BYTE_W 8
`define PSD_ADDR_W 6
`define PSD_BURST_LEN 4
`define PSD_ZERO_DATA 8'h00
`define PSD_ZERO_PAR 1'b0
`define PSD_BURST_ZERO 2'h0
`define PSD_BURST_ONE 2'h1
`define PSD_ALL_OFF 4'hf
`endif

//--- logic/psd_pkg.sv
package psd_pkg;
  typedef enum logic [1:0] {
    PSD_IDLE,
    PSD_READ,
    PSD_WRITE
  } psd_op_t;
  typedef enum logic {
    PSD_LINEAR,
    PSD_INTERLEAVED
  } psd_order_t;
endpackage

//--- logic/psd_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "psd_defs.svh"
interface psd_mem_if;
  logic [`PSD_ADDR_W-1:0] addr;
  logic [`PSD_LANES-1:0] wrLane;
  logic [`PSD_LANES*9-1:0] wrData;
  logic [`PSD_LANES*9-1:0] rdData;
  logic hold;
  modport ctrl (
    output addr,
    output wrLane,
    output wrData,
    output hold,
    input rdData
  );
  modport mem (
    input addr,
    input wrLane,
    input wrData,
    input hold,
    output rdData
  );
endinterface
`default_nettype wire

//--- logic/psd_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "psd_defs.svh"
module psd_array #(
  parameter int DEPTH = 1 << `PSD_ADDR_W
) (
  input wire logic clk,
  psd_mem_if.mem port
);
  logic [`PSD_LANES*9-1:0] store [DEPTH];
  logic [`PSD_LANES*9-1:0] rdReg;
  logic [`PSD_LANES*9-1:0] next_rdReg;
  logic [`PSD_LANES*9-1:0] merged;

  // Array itself has no reset; contents are undefined until written
  always_comb begin
    next_rdReg = port.hold ? rdReg : store[port.addr];
  end

  always_ff @(posedge clk) begin
    rdReg <= next_rdReg;
  end

  genvar g;
  generate
    for (g = 0; g < `PSD_LANES; g++) begin : gLane
      // Unselected lanes keep their old contents
      assign merged[g*9 +: 9] = port.wrLane[g] ? port.wrData[g*9 +: 9] :
                                store[port.addr][g*9 +: 9];
    end
  endgenerate

  // One writer process for the whole word
  always_ff @(posedge clk) begin
    if (!port.hold && (|port.wrLane)) begin
      store[port.addr] <= merged;
    end
  end

  assign port.rdData = rdReg;
endmodule
`default_nettype wire

//--- tb/psd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Controller facing the data port
module psd_ctrl_model (
  input wire logic clk,
  input wire logic [1:0] op,
  input wire logic adv,
  input wire logic [5:0] a,
  input wire logic [3:0] sel,
  input wire logic [35:0] wd,
  output logic chipSel_n,
  output logic writeEn_n,
  output logic advLoad_n,
  output logic [5:0] addrIn,
  output logic [3:0] byteSel_n,
  output logic [35:0] busIn
);
  logic pend = 1'b0;
  logic [35:0] held = 36'h0;
  logic [35:0] last = 36'h0;
  logic isWr;
  assign isWr = op == psd_pkg::PSD_WRITE && !adv;
  assign chipSel_n = op == psd_pkg::PSD_IDLE && !adv;
  assign writeEn_n = !isWr;
  assign advLoad_n = adv;
  assign addrIn = a;
  // Selects only mean something together with the write strobe
  assign byteSel_n = isWr ? sel : 4'hf;
  // Off the data phase the lines toggle, so stale data never passes
  assign busIn = pend ? held : ~last;
  always @(posedge clk) begin
    pend <= isWr;
    held <= wd;
    last <= busIn;
  end
endmodule
`default_nettype wire

//--- tb/pipelined_sram_data_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_data_port_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic qualN = 1'b0;
  logic oeN = 1'b0;
  logic mode = 1'b1;
  psd_pkg::psd_op_t op = psd_pkg::PSD_IDLE;
  logic adv = 1'b0;
  logic [5:0] a = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [35:0] wd = 36'h0;
  wire logic csN, weN, ldN;
  wire logic [5:0] addrPin;
  wire logic [3:0] selPin;
  wire logic [35:0] busPin;
  logic [31:0] dOut, dOe;
  logic [3:0] pOut, pOe;
  logic [35:0] mem [64];
  logic [37:0] q[$];
  logic [5:0] base = 6'h00;
  logic [1:0] cnt = 2'h0;
  int error_cnt = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  psd_ctrl_model ctrl (.clk(clk), .op(op), .adv(adv), .a(a), .sel(sel),
    .wd(wd), .chipSel_n(csN), .writeEn_n(weN), .advLoad_n(ldN),
    .addrIn(addrPin), .byteSel_n(selPin), .busIn(busPin));
  psd_data_port uut (.clk(clk), .reset(reset), .clkEn(1'b1),
    .clk_qualify_n(qualN), .chipSel_n(csN), .writeEn_n(weN),
    .advLoad_n(ldN), .outEn_n(oeN), .burstModePin(mode), .addrIn(addrPin),
    .byte_write_sel_n(selPin), .dataIn(busPin[31:0]),
    .parity_lines_in(busPin[35:32]), .dataOut(dOut),
    .parity_lines_out(pOut), .parity_lines_oe_n(pOe), .dataOe_n(dOe));

  // ====================
  // Scoreboard
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic look(input logic [37:0] e);
    if (e[37:36] == 2'd1) begin
      cmp({pOut, dOut}, e[35:0]);
      cmp({pOe, dOe}, 36'h0);
    end else if (e[37:36] == 2'd0) begin
      cmp({pOe, dOe}, 36'hfffffffff);
    end
  endtask

  // Slot kinds: 0 tristate, 1 read data, 2 left unchecked
  task automatic step(input psd_pkg::psd_op_t o, input logic ad,
                      input logic [5:0] ar, input logic [3:0] s);
    logic [35:0] d;
    logic [5:0] x;
    d = {4'($urandom), 32'($urandom)};
    @(negedge clk);
    if (q.size() == 3) look(q.pop_front());
    op = o;
    adv = ad;
    a = ar;
    sel = s;
    wd = d;
    if (ad) begin
      cnt = cnt + 2'h1;
      x = {base[5:2], mode ? base[1:0] ^ cnt : base[1:0] + cnt};
      q.push_back({2'd1, mem[x]});
    end else if (o == psd_pkg::PSD_READ) begin
      base = ar;
      cnt = 2'h0;
      // A read straight after deselect still returns its data
      q.push_back({2'd1, mem[ar]});
    end else if (o == psd_pkg::PSD_WRITE) begin
      for (int g = 0; g < 4; g++) begin
        if (!s[g]) begin
          mem[ar][8*g +: 8] = d[8*g +: 8];
          mem[ar][32+g] = d[32+g];
        end
      end
      // Bus slot that overlaps this write's data phase
      if (q.size() == 2) q[0][37:36] = 2'd0;
      q.push_back({2'd0, 36'h0});
    end else begin
      q.push_back({2'd0, 36'h0});
    end
  endtask

  task automatic mix();
    int r;
    r = $urandom % 6;
    if (r == 0) step(psd_pkg::PSD_IDLE, 1'b0, 6'h00, 4'h0);
    else if (r == 1) step(psd_pkg::PSD_WRITE, 1'b0, 6'($urandom), 4'($urandom));
    else begin
      step(psd_pkg::PSD_READ, 1'b0, 6'($urandom), 4'h0);
      if (r == 5) repeat (3) step(psd_pkg::PSD_READ, 1'b1, 6'h00, 4'h0);
    end
  endtask

  task automatic summarize();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h79e6));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) step(psd_pkg::PSD_IDLE, 1'b0, 6'h00, 4'h0);
    for (int i = 0; i < 64; i++) step(psd_pkg::PSD_WRITE, 1'b0, 6'(i), 4'h0);
    for (int m = 1; m >= 0; m--) begin
      repeat (3) step(psd_pkg::PSD_IDLE, 1'b0, 6'h00, 4'h0);
      mode = m[0];
      repeat (4) step(psd_pkg::PSD_IDLE, 1'b0, 6'h00, 4'h0);
      repeat (150) mix();
    end
    // Hold stretches a steady read; a write offered meanwhile is ignored
    repeat (4) step(psd_pkg::PSD_READ, 1'b0, 6'h05, 4'h0);
    for (int j = 0; j < 12; j++) begin
      @(negedge clk);
      cmp({pOut, dOut}, mem[5]);
      cmp({pOe, dOe}, 36'h0);
      qualN = j < 8;
      op = (j > 2 && j < 7) ? psd_pkg::PSD_WRITE : psd_pkg::PSD_READ;
      a = (j > 2 && j < 7) ? 6'h09 : 6'h05;
    end
    q.delete();
    repeat (4) step(psd_pkg::PSD_READ, 1'b0, 6'h09, 4'h0);
    for (int j = 0; j < 10; j++) begin
      @(negedge clk);
      if (j > 2 && j < 6) cmp({pOe, dOe}, 36'hfffffffff);
      if (j == 9) cmp({pOut, dOut, pOe, dOe[3:0]}, {mem[9], 8'h00});
      oeN = j < 5;
    end
    q.delete();
    summarize();
  end

  initial begin
    #400000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
